/* File: common/ctw_pkg.sv */
/*
 * Package for the clock timer: register indices, field positions,
 * reset values, tick timing and the packed state record.
 * Assumes a 100 MHz core clock and a 32-bit Avalon-MM register bus.
 */
package ctw_pkg;

    // ********************************************************
    // Clock and tick timing
    // ********************************************************
    localparam int          CORE_CLK_HZ  = 100_000_000;
    localparam int          TICK_HZ      = 256;
    localparam int          TICK_CYCLES  = CORE_CLK_HZ / TICK_HZ;
    localparam int          DIV_W        = 19;

    // ********************************************************
    // Register indices; byte address is four times the index
    // ********************************************************
    localparam int          ADDR_W       = 18;
    localparam logic [23:0] IDX_PRIO     = 24'h00_ff20;
    localparam logic [23:0] IDX_ENABLE   = 24'h00_ff22;
    localparam logic [23:0] IDX_FLAGS    = 24'h00_ff24;
    localparam logic [23:0] IDX_CTRL     = 24'h00_ff40;
    localparam logic [23:0] IDX_COUNT    = 24'h00_ff41;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int          CTRL_RUN_BIT   = 0;
    localparam int          CTRL_CLEAR_BIT = 1;
    localparam int          TAP_1HZ        = 7;
    localparam int          TAP_2HZ        = 6;
    localparam int          TAP_8HZ        = 4;
    localparam int          TAP_32HZ       = 2;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [7:0]  COUNT_RST    = 8'h00;
    localparam logic [1:0]  PRIO_RST     = 2'h0;
    localparam logic [3:0]  ENABLE_RST   = 4'h0;
    localparam logic [3:0]  FLAGS_RST    = 4'h0;

    // Complete state of the timer block
    typedef struct packed {
        logic [DIV_W-1:0] div_cnt;
        logic [7:0]       tick_count_bits;
        logic             run_written;
        logic             run_active;
        logic [1:0]       tick_irq_level;
        logic [3:0]       irq_enable;
        logic [3:0]       irq_flag;
        logic             bus_ack;
        logic [7:0]       rd_data;
    } ctw_state_s;

endpackage : ctw_pkg

/* File: rtl/ctw_clock_timer.sv */
/*
 * Clock timer: 8-bit up-counter on a 256 Hz tick, run/stop and clear
 * control, four tap interrupt flags with enables and a priority level.
 * Assumes a single 100 MHz core clock, an Avalon-MM master that holds
 * its request until waitrequest is low, and a CPU mask level input
 * driven from logic on the same clock.
 */
`timescale 1ns/100ps

// Behaviour
// [R01] Eight-bit binary up-counter advanced by a 256 Hz tick divided down.
// [R02] All count bits readable; bit 0 toggles at 128 Hz, bit 7 at 1 Hz.
// [R03] Count register is read-only and clears to zero at reset.
// [R04] Writing one to clear zeroes the count; running continues, stopped holds.
// [R05] Clear bit is write-only, reads zero, and writing zero does nothing.
// [R06] Run bit one counts, zero stops and keeps the count for resuming.
// [R07] Run bit resets to zero, meaning stopped.
// [R08] A run bit change acts only at the next 256 Hz falling edge.
// [R09] After writing stop, one more increment; run reads one until stopped.
// [R10] Two-bit priority field selects level 0 to 3, resets to level 0.
// [R11] Four read-write enables for 1, 2, 8, 32 Hz, reset disabled.
// [R12] Each flag sets at the falling edge of its 1, 2, 8, 32 Hz tap.
// [R13] Flags set whatever the enables or priority level are.
// [R14] Request CPU only if flag, enable set and level exceeds CPU mask.
// [R15] Writing one clears a flag, zero leaves it; flags reset to zero.
// [R16] Software stops the timer before sleep; running through sleep is unsafe.
// [R17] Count wraps from 0xFF to zero, giving the 1 Hz period on bit 7.
module ctw_clock_timer
    import ctw_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output logic      [31:0]       avs_readdata_o,
    output logic                   avs_waitrequest_o,
    input  wire logic [1:0]        cpu_mask_level_i,
    output logic                   tick_irq_o,
    output logic                   tick_irq_req_o,
    output logic      [1:0]        tick_irq_level_o
);

    // ********************************************************
    // State and decode
    // ********************************************************
    ctw_state_s       st;
    ctw_state_s       next_st;

    logic             req;
    logic             acc;
    logic             wr_acc;
    logic             wr_lo;
    logic [7:0]       wr_byte;
    logic             tick;
    logic             do_inc;
    logic             do_clear;
    logic [7:0]       inc_val;
    logic [7:0]       falls;
    logic [3:0]       flag_set;
    logic             sel_prio;
    logic             sel_enable;
    logic             sel_flags;
    logic             sel_ctrl;
    logic             sel_count;

    // Registers sit one per word, so each index is a word address
    assign sel_prio   = ({6'h00, avs_address_i} == {IDX_PRIO[21:0],   2'b00});
    assign sel_enable = ({6'h00, avs_address_i} == {IDX_ENABLE[21:0], 2'b00});
    assign sel_flags  = ({6'h00, avs_address_i} == {IDX_FLAGS[21:0],  2'b00});
    assign sel_ctrl   = ({6'h00, avs_address_i} == {IDX_CTRL[21:0],   2'b00});
    assign sel_count  = ({6'h00, avs_address_i} == {IDX_COUNT[21:0],  2'b00});

    // Every access takes exactly one wait cycle so read data is a flop
    assign req               = avs_read_i | avs_write_i;
    assign acc               = req & st.bus_ack;
    assign avs_waitrequest_o = req & ~st.bus_ack;
    assign wr_acc            = acc & avs_write_i;
    assign wr_lo             = wr_acc & avs_byteenable_i[0];
    assign wr_byte           = avs_writedata_i[7:0];

    // ********************************************************
    // Tick generation and counting
    // ********************************************************

    // One enable pulse per 256 Hz period stands for its falling edge
    assign tick     = (st.div_cnt == DIV_W'(TICK_DIV - 1)); // see [R01]
    assign do_clear = wr_lo & sel_ctrl & wr_byte[CTRL_CLEAR_BIT]; // see [R04] [R05]
    // Count uses the run state before this edge, so a stop still increments
    assign do_inc   = tick & st.run_active; // see [R09]
    assign inc_val  = st.tick_count_bits + 8'h01; // see [R17]
    // A tap falls where the increment carries a one to zero
    assign falls    = do_inc ? (st.tick_count_bits & ~inc_val) : 8'h00;
    assign flag_set = {falls[TAP_32HZ], falls[TAP_8HZ],
                       falls[TAP_2HZ], falls[TAP_1HZ]}; // see [R12] [R13]

    // Next-state logic for the whole block
    always_comb begin
        next_st = st;

        // Divider free-runs; it is the low-speed time base
        if (tick) begin
            next_st.div_cnt = '0;
        end else begin
            next_st.div_cnt = st.div_cnt + DIV_W'(1);
        end

        // Clear wins over a coinciding increment and leaves run alone
        if (do_clear) begin
            next_st.tick_count_bits = COUNT_RST; // see [R04]
        end else if (do_inc) begin
            next_st.tick_count_bits = inc_val; // see [R02] [R17]
        end

        // Written run value is taken over only on the tick
        if (wr_lo && sel_ctrl) begin
            next_st.run_written = wr_byte[CTRL_RUN_BIT]; // see [R06]
        end
        if (tick) begin
            next_st.run_active = st.run_written; // see [R08]
        end

        if (wr_lo && sel_prio) begin
            next_st.tick_irq_level = wr_byte[1:0]; // see [R10]
        end
        if (wr_lo && sel_enable) begin
            next_st.irq_enable = wr_byte[3:0]; // see [R11]
        end

        // Write-one clears, but a new tap edge in that cycle wins
        next_st.irq_flag = st.irq_flag;
        if (wr_lo && sel_flags) begin
            next_st.irq_flag = st.irq_flag & ~wr_byte[3:0]; // see [R15]
        end
        next_st.irq_flag = next_st.irq_flag | flag_set; // see [R12]

        // Acknowledge one cycle after the request arrives
        next_st.bus_ack = req & ~st.bus_ack;

        // Read data captured during the wait cycle; unmapped reads zero
        next_st.rd_data = 8'h00;
        if (avs_read_i && !st.bus_ack) begin
            case (1'b1)
                sel_prio: begin
                    next_st.rd_data = {6'h00, st.tick_irq_level};
                end
                sel_enable: begin
                    next_st.rd_data = {4'h0, st.irq_enable};
                end
                sel_flags: begin
                    next_st.rd_data = {4'h0, st.irq_flag};
                end
                sel_ctrl: begin
                    // Clear reads zero; run reads one until the stop lands
                    next_st.rd_data = {7'h00, st.run_written | st.run_active}; // see [R05] [R09]
                end
                sel_count: begin
                    next_st.rd_data = st.tick_count_bits; // see [R02] [R03]
                end
                default: begin
                    next_st.rd_data = 8'h00;
                end
            endcase
        end
    end

    // State register, asynchronous reset to constants only
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st.div_cnt         <= '0;
            st.tick_count_bits <= COUNT_RST; // see [R03]
            st.run_written     <= 1'b0; // see [R07]
            st.run_active      <= 1'b0; // see [R07]
            st.tick_irq_level  <= PRIO_RST; // see [R10]
            st.irq_enable      <= ENABLE_RST; // see [R11]
            st.irq_flag        <= FLAGS_RST; // see [R15]
            st.bus_ack         <= 1'b0;
            st.rd_data         <= 8'h00;
        end else begin
            st <= next_st;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************

    // Level 0 never exceeds any mask, so it never requests
    assign avs_readdata_o   = {24'h00_0000, st.rd_data};
    assign tick_irq_o       = |(st.irq_flag & st.irq_enable);
    assign tick_irq_req_o   = tick_irq_o &&
                              (st.tick_irq_level > cpu_mask_level_i); // see [R14]
    assign tick_irq_level_o = st.tick_irq_level;

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_stop_written;
        wr_lo && sel_ctrl && !wr_byte[CTRL_RUN_BIT] && st.run_active && !tick;
    endsequence

    sequence s_stop_lands;
        tick && st.run_active && !st.run_written;
    endsequence

    property p_count_ro;
        wr_acc && sel_count && !tick |=> $stable(st.tick_count_bits);
    endproperty
    a_count_ro: assert property (p_count_ro) // see [R03]
        else $error("count changed by a bus write");

    property p_clear_zero;
        do_clear |=> st.tick_count_bits == 8'h00;
    endproperty
    a_clear_zero: assert property (p_clear_zero) // see [R04]
        else $error("clear did not zero count");

    property p_clear_reads_zero;
        avs_read_i && st.bus_ack && sel_ctrl |-> avs_readdata_o[CTRL_CLEAR_BIT] == 1'b0;
    endproperty
    a_clear_reads_zero: assert property (p_clear_reads_zero) // see [R05]
        else $error("clear bit read as one");

    property p_count_step;
        tick && st.run_active && !do_clear
            |=> st.tick_count_bits == $past(st.tick_count_bits) + 8'h01;
    endproperty
    a_count_step: assert property (p_count_step) // see [R06]
        else $error("count did not step by one");

    property p_run_on_tick;
        $changed(st.run_active) |-> $past(tick);
    endproperty
    a_run_on_tick: assert property (p_run_on_tick) // see [R08]
        else $error("run changed off the tick");

    property p_stop_once;
        s_stop_written ##1 (!tick)[*1] |-> st.run_active;
    endproperty
    a_stop_once: assert property (p_stop_once) // see [R09]
        else $error("stopped before the tick");

    property p_stop_final;
        s_stop_lands and !do_clear
            |=> !st.run_active && st.tick_count_bits == $past(st.tick_count_bits) + 8'h01;
    endproperty
    a_stop_final: assert property (p_stop_final) // see [R09]
        else $error("no final increment on stop");

    property p_wrap;
        do_inc && !do_clear && st.tick_count_bits == 8'hff
            |=> st.tick_count_bits == 8'h00 && st.irq_flag[0];
    endproperty
    a_wrap: assert property (p_wrap) // see [R17] [R12]
        else $error("wrap or 1 Hz flag missing");

    property p_set_over_clear;
        |flag_set |=> (st.irq_flag & $past(flag_set)) == $past(flag_set);
    endproperty
    a_set_over_clear: assert property (p_set_over_clear) // see [R13]
        else $error("tap edge lost");

    property p_w1c;
        wr_lo && sel_flags && wr_byte[0] && !flag_set[0] |=> !st.irq_flag[0];
    endproperty
    a_w1c: assert property (p_w1c) // see [R15]
        else $error("flag not cleared by one");

    property p_request;
        tick_irq_req_o |-> tick_irq_o && st.tick_irq_level != 2'h0;
    endproperty
    a_request: assert property (p_request) // see [R14]
        else $error("request without cause");

    property p_wait_one;
        req && avs_waitrequest_o |=> !avs_waitrequest_o;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest held too long");

    // ********************************************************
    // Start, hold, tap and request checks
    // ********************************************************

    // A start waits for the tick and counts only from the tick after
    sequence s_start_written;
        wr_lo && sel_ctrl && wr_byte[CTRL_RUN_BIT] && !st.run_active && !tick;
    endsequence

    sequence s_start_lands;
        tick && !st.run_active && st.run_written;
    endsequence

    property p_start_late;
        s_start_written |=> !st.run_active;
    endproperty
    a_start_late: assert property (p_start_late) // see [R08]
        else $error("run started before the tick");

    property p_start_first;
        s_start_lands and !do_clear |=> st.run_active && $stable(st.tick_count_bits);
    endproperty
    a_start_first: assert property (p_start_first) // see [R08]
        else $error("count moved on the starting tick");

    // Between ticks only a clear may move the count
    property p_hold_off_tick;
        !tick && !do_clear |=> $stable(st.tick_count_bits);
    endproperty
    a_hold_off_tick: assert property (p_hold_off_tick) // see [R01]
        else $error("count moved between ticks");

    property p_stopped_holds;
        !st.run_active && !do_clear |=> $stable(st.tick_count_bits);
    endproperty
    a_stopped_holds: assert property (p_stopped_holds) // see [R06]
        else $error("stopped count moved");

    // A tap falls when it and every bit below it roll over together
    property p_tap_32hz;
        do_inc && st.tick_count_bits[TAP_32HZ:0] == 3'h7 |=> st.irq_flag[3];
    endproperty
    a_tap_32hz: assert property (p_tap_32hz) // see [R12]
        else $error("32 Hz flag not set");

    property p_tap_8hz;
        do_inc && st.tick_count_bits[TAP_8HZ:0] == 5'h1f |=> st.irq_flag[2];
    endproperty
    a_tap_8hz: assert property (p_tap_8hz) // see [R12]
        else $error("8 Hz flag not set");

    property p_tap_2hz;
        do_inc && st.tick_count_bits[TAP_2HZ:0] == 7'h7f |=> st.irq_flag[1];
    endproperty
    a_tap_2hz: assert property (p_tap_2hz) // see [R12]
        else $error("2 Hz flag not set");

    // A flag rises only on its own tap edge and stays until written
    property p_flag_rise;
        (st.irq_flag & ~$past(st.irq_flag) & ~$past(flag_set)) == 4'h0;
    endproperty
    a_flag_rise: assert property (p_flag_rise) // see [R12]
        else $error("flag rose without a tap edge");

    property p_flag_sticky;
        !(wr_lo && sel_flags) |=> (st.irq_flag & $past(st.irq_flag)) == $past(st.irq_flag);
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) // see [R15]
        else $error("flag dropped without a write");

    property p_w0_keeps;
        wr_lo && sel_flags && !wr_byte[1] && st.irq_flag[1] |=> st.irq_flag[1];
    endproperty
    a_w0_keeps: assert property (p_w0_keeps) // see [R15]
        else $error("writing zero cleared a flag");

    // Enables gate tick_irq_o; the priority must beat the mask
    property p_irq_disabled;
        st.irq_enable == 4'h0 |-> !tick_irq_o;
    endproperty
    a_irq_disabled: assert property (p_irq_disabled) // see [R11]
        else $error("interrupt with all enables off");

    property p_irq_raised;
        st.irq_flag[1] && st.irq_enable[1] |-> tick_irq_o;
    endproperty
    a_irq_raised: assert property (p_irq_raised) // see [R14]
        else $error("enabled flag gave no interrupt");

    property p_req_blocked;
        st.tick_irq_level <= cpu_mask_level_i |-> !tick_irq_req_o;
    endproperty
    a_req_blocked: assert property (p_req_blocked) // see [R14]
        else $error("request at or below the mask");

    property p_req_top;
        tick_irq_o && st.tick_irq_level == 2'h3 && cpu_mask_level_i != 2'h3 |-> tick_irq_req_o;
    endproperty
    a_req_top: assert property (p_req_top) // see [R14]
        else $error("level 3 request missing");

endmodule : ctw_clock_timer

/* File: tb/ctw_clock_timer_bench.sv */
/*
 * Self-checking bench for the clock timer: register access, run/stop,
 * clear, tap flags, enables and priority level toward the CPU.
 * Assumes an Avalon-MM slave with waitrequest and a shortened tick.
 */
`timescale 1ns/100ps
module ctw_clock_timer_bench;
    import ctw_pkg::*;
    // Short tick keeps a full 256-step wrap near 4k cycles
    localparam int TDIV = 16;
    logic              core_clk_i = 1'b0;
    logic              rst_i = 1'b1;
    logic [ADDR_W-1:0] avs_address_i = '0;
    logic              avs_read_i = 1'b0;
    logic              avs_write_i = 1'b0;
    logic [31:0]       avs_writedata_i = '0;
    logic [3:0]        avs_byteenable_i = 4'h0;
    logic [31:0]       avs_readdata_o;
    logic              avs_waitrequest_o;
    logic [1:0]        cpu_mask_level_i = 2'h0;
    logic              tick_irq_o;
    logic              tick_irq_req_o;
    logic [1:0]        tick_irq_level_o;
    int                n_fail = 0;
    int                num_checks = 0;
    logic [7:0]        rd;
    logic [7:0]        c;
    int                n_wait = 0;
    ctw_clock_timer #(.TICK_DIV(TDIV)) u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .cpu_mask_level_i(cpu_mask_level_i), .tick_irq_o(tick_irq_o),
        .tick_irq_req_o(tick_irq_req_o), .tick_irq_level_o(tick_irq_level_o));
    always #5 core_clk_i = ~core_clk_i;
    // ********************************************************
    // Bus and compare helpers
    // ********************************************************
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Request held from just after an edge until waitrequest is sampled low at an edge
    task automatic bus(input logic is_wr, input logic [23:0] idx, input logic [7:0] d,
                       input logic [3:0] be);
        avs_address_i <= ADDR_W'(idx << 2);
        avs_read_i <= ~is_wr;
        avs_write_i <= is_wr;
        avs_writedata_i <= {24'h00_0000, d};
        avs_byteenable_i <= be;
        n_wait = 0;
        @(posedge core_clk_i);
        while (avs_waitrequest_o !== 1'b0) begin
            n_wait++;
            @(posedge core_clk_i);
        end
        rd = avs_readdata_o[7:0];
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        // Idle edge so the strobes are never written twice in one step
        @(posedge core_clk_i);
    endtask : bus
    task automatic wr(input logic [23:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 4'h1);
    endtask : wr
    task automatic rchk(input string what, input logic [23:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00, 4'hf);
        chk(what, exp, rd);
    endtask : rchk
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask : cyc
    // ********************************************************
    // Scenarios
    // ********************************************************
    task automatic t_reset;
        rchk("prio", IDX_PRIO, 8'h00);
        chk("wait states", 8'h01, 8'(n_wait));
        rchk("enable", IDX_ENABLE, 8'h00);
        rchk("flags", IDX_FLAGS, 8'h00);
        rchk("ctrl", IDX_CTRL, 8'h00);
        cyc(5 * TDIV);
        rchk("count", IDX_COUNT, 8'h00);
        wr(IDX_COUNT, 8'h5a);
        rchk("count ro", IDX_COUNT, 8'h00);
        bus(1'b1, IDX_ENABLE, 8'h0f, 4'h0);
        rchk("be0 write", IDX_ENABLE, 8'h00);
        rchk("unmapped", 24'h00_ff30, 8'h00);
        $display("test reset done");
    endtask : t_reset
    task automatic t_run_stop;
        wr(IDX_CTRL, 8'h01);
        cyc(4 * TDIV);
        bus(1'b0, IDX_COUNT, 8'h00, 4'hf);
        c = rd;
        chk("counting", 8'h01, {7'h0, c > 8'h01});
        // Align to a tick by watching the count move, then stop right after it
        for (int i = 0; i < 40 && rd == c; i++) bus(1'b0, IDX_COUNT, 8'h00, 4'hf);
        c = rd;
        wr(IDX_CTRL, 8'h00);
        rchk("run until stop", IDX_CTRL, 8'h01);
        cyc(3 * TDIV);
        rchk("one more step", IDX_COUNT, c + 8'h01);
        rchk("stopped", IDX_CTRL, 8'h00);
        cyc(3 * TDIV);
        rchk("held", IDX_COUNT, c + 8'h01);
        wr(IDX_CTRL, 8'h02);
        rchk("clear reads 0", IDX_CTRL, 8'h00);
        rchk("cleared", IDX_COUNT, 8'h00);
        cyc(3 * TDIV);
        rchk("clear held", IDX_COUNT, 8'h00);
        $display("test run_stop done");
    endtask : t_run_stop
    task automatic t_flags;
        wr(IDX_CTRL, 8'h01);
        cyc(262 * TDIV);
        wr(IDX_CTRL, 8'h00);
        cyc(3 * TDIV);
        // A full wrap makes every tap fall, bit 7 only on 0xFF to 0x00
        rchk("all flags", IDX_FLAGS, 8'h0f);
        chk("irq masked", 8'h00, {7'h0, tick_irq_o});
        wr(IDX_PRIO, 8'h02);
        wr(IDX_ENABLE, 8'h01);
        rchk("enable rw", IDX_ENABLE, 8'h01);
        cpu_mask_level_i <= 2'h1;
        cyc(2);
        chk("irq", 8'h01, {7'h0, tick_irq_o});
        chk("req", 8'h01, {7'h0, tick_irq_req_o});
        chk("level", 8'h02, {6'h0, tick_irq_level_o});
        cpu_mask_level_i <= 2'h2;
        cyc(2);
        chk("req masked", 8'h00, {7'h0, tick_irq_req_o});
        wr(IDX_FLAGS, 8'h00);
        rchk("w0 keeps", IDX_FLAGS, 8'h0f);
        wr(IDX_FLAGS, 8'h01);
        rchk("w1c", IDX_FLAGS, 8'h0e);
        chk("irq gone", 8'h00, {7'h0, tick_irq_o});
        wr(IDX_ENABLE, 8'h02);
        cpu_mask_level_i <= 2'h0;
        for (int p = 0; p < 4; p++) begin
            wr(IDX_PRIO, 8'(p));
            rchk("prio rw", IDX_PRIO, 8'(p));
            chk("lvl", 8'(p), {6'h0, tick_irq_level_o});
            chk("req lvl", 8'(p != 0), {7'h0, tick_irq_req_o});
        end
        $display("test flags done");
    endtask : t_flags
    // ********************************************************
    // Closing, sequence and watchdog
    // ********************************************************
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    initial begin
        cyc(2);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        t_reset();
        t_run_stop();
        t_flags();
        end_of_test();
    end
    // Tests need about 4.7k cycles; five times that means a hang
    initial begin
        cyc(24000);
        n_fail++;
        end_of_test();
    end
endmodule : ctw_clock_timer_bench
